// file: bmp_consts.vh
// Constants for the boot memory and serial EEPROM port
`ifndef BMP_CONSTS_VH
`define BMP_CONSTS_VH

// Core clock rate in MHz
`define BMP_CLK_MHZ 20
// Least time to whole cycles, never below one
`define BMP_CYC_MIN(ns) ((((ns) * `BMP_CLK_MHZ + 999) / 1000) < 1 ? 1 : \
  (((ns) * `BMP_CLK_MHZ + 999) / 1000))

// Access phase times in ns
`define BMP_SETUP_NS 50
`define BMP_READ_NS 150
`define BMP_WRITE_NS 100
`define BMP_HOLD_NS 50
// Strap settle time after reset release in ns
`define BMP_STRAP_NS 400

// Boot memory geometry: 128 KB of bytes
`define BMP_ADDR_W 17
`define BMP_DATA_W 8

// Pin positions inside the address bus
`define BMP_PIN_AUX 8
`define BMP_PIN_SIZE 6
`define BMP_PIN_SK 2
`define BMP_PIN_DI 1
`define BMP_PIN_DO 0

// Sequencer state codes
`define BMP_ST_IDLE 3'h0
`define BMP_ST_SETUP 3'h1
`define BMP_ST_READ 3'h2
`define BMP_ST_WRITE 3'h3
`define BMP_ST_HOLD 3'h4

`endif

// file: bmp_mem_model.sv
// Boot memory and serial EEPROM model
module bmp_mem_model (
  input logic clk,
  input logic selN,
  input logic oeN,
  input logic weN,
  input logic [16:0] addr,
  input logic [16:0] addrOe,
  input logic [7:0] wrData,
  input logic eeSel,
  input logic auxPull,
  input logic sizePull,
  output logic [7:0] rdData,
  output logic auxPin,
  output logic sizePin,
  output logic serialIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [int];
  logic [7:0] lastRd = 8'h00;
  logic eeBit = 1'b0;
  always @(posedge weN) if (!selN) mem[addr] = wrData;
  always @* rdData = (!selN && !oeN) ?
    (mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[15:8]) : ~lastRd;
  always @(posedge clk) if (!selN && !oeN) lastRd <= rdData;
  always @(posedge clk) if (eeSel) eeBit <= ~eeBit;
  assign serialIn = eeSel ? eeBit : ~eeBit;
  assign auxPin = addrOe[8] ? addr[8] : auxPull;
  assign sizePin = addrOe[6] ? addr[6] : sizePull;
endmodule

// file: bmp_port.v
// Boot memory and serial EEPROM pin port
// How it works
// - Seventeen-bit address bus reaches a boot memory of up to 128 kilobytes.
// - Aux power pin sampled after reset; low means no aux power.
// - Size pin latched after reset; high picks larger EEPROM, then plain address.
// - In EEPROM mode low pins carry serial clock, data out, data in.
// - Eight-bit two-way data bus carries boot memory bytes.
// - Boot memory select asserted for every boot memory access.
// - Read enable asserted during reads so memory drives the bus.
// - Write strobe pulsed during flash writes with data on the bus.
`include "bmp_consts.vh"

module bmp_port #(
  parameter ADDR_W = `BMP_ADDR_W,
  parameter DATA_W = `BMP_DATA_W,
  parameter CNT_W = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire memReq,
  input wire memWrite,
  input wire [ADDR_W-1:0] memAddr,
  input wire [DATA_W-1:0] memWrData,
  output wire memReady,
  output reg [DATA_W-1:0] memRdData_r,
  output reg memDone_r,
  input wire eepromMode,
  input wire eepromSerialClockReq,
  input wire eepromSerialOutReq,
  input wire eepromSelectReq,
  output reg eepromSerialIn_r,
  output wire auxPowerPresent,
  output wire largeEepromSelect,
  output wire strapDone,
  output reg [ADDR_W-1:0] bootMemAddrBusOut_r,
  output reg [ADDR_W-1:0] bootMemAddrBusOe_r,
  input wire auxPowerDetectAddrPinIn,
  input wire eepromSizeSelectAddrPinIn,
  input wire lowAddrSerialSharedIn,
  output reg eepromSelect_r,
  input wire [DATA_W-1:0] bootMemDataBusIn,
  output reg [DATA_W-1:0] bootMemDataBusOut_r,
  output reg bootMemDataBusOe_r,
  output reg bootMemSelectN_r,
  output reg bootMemReadEnableN_r,
  output reg flashWriteStrobeN_r
);
  localparam integer SETUP_I = `BMP_CYC_MIN(`BMP_SETUP_NS);
  localparam integer READ_I = `BMP_CYC_MIN(`BMP_READ_NS);
  localparam integer WRITE_I = `BMP_CYC_MIN(`BMP_WRITE_NS);
  localparam integer HOLD_I = `BMP_CYC_MIN(`BMP_HOLD_NS);
  localparam [CNT_W-1:0] SETUP_CYC = SETUP_I[CNT_W-1:0];
  localparam [CNT_W-1:0] READ_CYC = READ_I[CNT_W-1:0];
  localparam [CNT_W-1:0] WRITE_CYC = WRITE_I[CNT_W-1:0];
  localparam [CNT_W-1:0] HOLD_CYC = HOLD_I[CNT_W-1:0];

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [CNT_W-1:0] cnt_r;
  reg [CNT_W-1:0] cnt_nxt;
  reg isWrite_r;
  reg eeActive_r;
  wire take;
  wire nxtIdle;
  wire nxtRead;
  wire nxtWrite;
  wire readLast;
  wire lendPins;

  // True on the last cycle of a phase of the given length
  function phaseEnd;
    input [CNT_W-1:0] cnt;
    input [CNT_W-1:0] len;
    begin
      phaseEnd = (cnt == len - 1'b1);
    end
  endfunction

  bmp_strap_latch #(
    .CNT_W(CNT_W)
  ) strapLatch (
    .clk(clk),
    .sys_rst(sys_rst),
    .auxPinIn(auxPowerDetectAddrPinIn),
    .sizePinIn(eepromSizeSelectAddrPinIn),
    .strapDone_r(strapDone),
    .auxPowerPresent_r(auxPowerPresent),
    .largeEepromSelect_r(largeEepromSelect)
  );

  // Accept only when idle, straps done and pins not lent to the EEPROM
  assign memReady = strapDone && !eepromMode && !eeActive_r && (state_r == `BMP_ST_IDLE);
  assign take = memReq && memReady;

  // Decoded next state and pin lending
  assign nxtIdle = (state_nxt == `BMP_ST_IDLE);
  assign nxtRead = (state_nxt == `BMP_ST_READ);
  assign nxtWrite = (state_nxt == `BMP_ST_WRITE);
  assign readLast = (state_r == `BMP_ST_READ) && phaseEnd(cnt_r, READ_CYC);
  assign lendPins = strapDone && eepromMode && nxtIdle && !take;

  // Access sequencer
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r + 1'b1;
    case (state_r)
      `BMP_ST_IDLE:
      begin
        cnt_nxt = {CNT_W{1'b0}};
        if (take)
        begin
          state_nxt = `BMP_ST_SETUP;
        end
      end
      `BMP_ST_SETUP:
      begin
        if (phaseEnd(cnt_r, SETUP_CYC))
        begin
          cnt_nxt = {CNT_W{1'b0}};
          state_nxt = isWrite_r ? `BMP_ST_WRITE : `BMP_ST_READ;
        end
      end
      `BMP_ST_READ:
      begin
        if (phaseEnd(cnt_r, READ_CYC))
        begin
          cnt_nxt = {CNT_W{1'b0}};
          state_nxt = `BMP_ST_HOLD;
        end
      end
      `BMP_ST_WRITE:
      begin
        if (phaseEnd(cnt_r, WRITE_CYC))
        begin
          cnt_nxt = {CNT_W{1'b0}};
          state_nxt = `BMP_ST_HOLD;
        end
      end
      `BMP_ST_HOLD:
      begin
        if (phaseEnd(cnt_r, HOLD_CYC))
        begin
          cnt_nxt = {CNT_W{1'b0}};
          state_nxt = `BMP_ST_IDLE;
        end
      end
      default:
      begin
        cnt_nxt = {CNT_W{1'b0}};
        state_nxt = `BMP_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r <= `BMP_ST_IDLE;
      cnt_r <= {CNT_W{1'b0}};
      isWrite_r <= 1'b0;
      memDone_r <= 1'b0;
      memRdData_r <= {DATA_W{1'b0}};
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      memDone_r <= (state_r == `BMP_ST_HOLD) && phaseEnd(cnt_r, HOLD_CYC);
      if (take)
      begin
        isWrite_r <= memWrite;
      end
      if (readLast)
      begin
        memRdData_r <= bootMemDataBusIn;
      end
    end
  end

  // Boot memory strobes, data bus and address pins
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      bootMemSelectN_r <= 1'b1;
      bootMemReadEnableN_r <= 1'b1;
      flashWriteStrobeN_r <= 1'b1;
      bootMemDataBusOut_r <= {DATA_W{1'b0}};
      bootMemDataBusOe_r <= 1'b0;
      bootMemAddrBusOut_r <= {ADDR_W{1'b0}};
      bootMemAddrBusOe_r <= {ADDR_W{1'b0}};
      eepromSelect_r <= 1'b0;
      eepromSerialIn_r <= 1'b0;
      eeActive_r <= 1'b0;
    end
    else
    begin
      bootMemSelectN_r <= nxtIdle;
      bootMemReadEnableN_r <= !nxtRead;
      flashWriteStrobeN_r <= !nxtWrite;
      if (take)
      begin
        bootMemAddrBusOut_r <= memAddr;
        bootMemDataBusOut_r <= memWrData;
      end
      bootMemDataBusOe_r <= !nxtIdle && (take ? memWrite : isWrite_r);
      eeActive_r <= eepromMode && nxtIdle;
      // Straps must be undriven until sampled, then all pins drive except DO while lent to the EEPROM
      bootMemAddrBusOe_r <= strapDone ? {ADDR_W{1'b1}} : {ADDR_W{1'b0}};
      eepromSelect_r <= 1'b0;
      eepromSerialIn_r <= lowAddrSerialSharedIn;
      if (lendPins)
      begin
        bootMemAddrBusOut_r[`BMP_PIN_SK] <= eepromSerialClockReq;
        bootMemAddrBusOut_r[`BMP_PIN_DI] <= eepromSerialOutReq;
        bootMemAddrBusOe_r[`BMP_PIN_DO] <= 1'b0;
        eepromSelect_r <= eepromSelectReq;
      end
    end
  end
endmodule

// file: bmp_port_asserts.sv
// Checker for the boot memory port pins
module bmp_port_asserts (
  input logic clk,
  input logic sys_rst,
  input logic memReq,
  input logic memWrite,
  input logic memReady,
  input logic memDone_r,
  input logic eepromMode,
  input logic eepromSerialClockReq,
  input logic eepromSerialOutReq,
  input logic eepromSelectReq,
  input logic strapDone,
  input logic auxPowerPresent,
  input logic largeEepromSelect,
  input logic [16:0] bootMemAddrBusOut_r,
  input logic [16:0] bootMemAddrBusOe_r,
  input logic eepromSelect_r,
  input logic bootMemDataBusOe_r,
  input logic bootMemSelectN_r,
  input logic bootMemReadEnableN_r,
  input logic flashWriteStrobeN_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_rdWalk;
    ##1 !bootMemSelectN_r ##1 !bootMemReadEnableN_r [*3] ##1 bootMemReadEnableN_r
    ##1 (memDone_r && bootMemSelectN_r);
  endsequence
  sequence s_wrWalk;
    ##1 (!bootMemSelectN_r && bootMemDataBusOe_r) ##1 !flashWriteStrobeN_r [*2]
    ##1 flashWriteStrobeN_r ##1 (memDone_r && bootMemSelectN_r && !bootMemDataBusOe_r);
  endsequence
  a_read_walk: assert property (memReq && memReady && !memWrite |-> s_rdWalk)
    else $error("read cycle shape wrong");
  a_write_walk: assert property (memReq && memReady && memWrite |-> s_wrWalk)
    else $error("write cycle shape wrong");
  a_idle_high: assert property (bootMemSelectN_r |->
    bootMemReadEnableN_r && flashWriteStrobeN_r)
    else $error("strobe active without select");
  a_bus_clash: assert property (!bootMemReadEnableN_r |-> !bootMemDataBusOe_r)
    else $error("data bus driven during read");
  a_strap_time: assert property ($fell(sys_rst) |-> !strapDone ##[6:10] strapDone)
    else $error("straps not latched in time");
  a_strap_hold: assert property (strapDone |=> strapDone && $stable(largeEepromSelect)
    && $stable(auxPowerPresent))
    else $error("strap result changed");
  a_ee_pins: assert property (eepromMode && strapDone && bootMemSelectN_r |=>
    bootMemAddrBusOut_r[2] == $past(eepromSerialClockReq) && !bootMemAddrBusOe_r[0]
    && bootMemAddrBusOut_r[1] == $past(eepromSerialOutReq)
    && eepromSelect_r == $past(eepromSelectReq))
    else $error("serial pins do not follow requests");
  a_ee_block: assert property (eepromMode |-> !memReady ##1 !memReady)
    else $error("memory ready in serial mode");
endmodule
bind bmp_port bmp_port_asserts bmp_port_asserts_inst (.*);

// file: bmp_port_tb.sv
// Testbench for the boot memory port
module bmp_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, memReq = 0, memWrite = 0, eepromMode = 0, auxPull = 1;
  logic eepromSerialClockReq = 0, eepromSerialOutReq = 0, eepromSelectReq = 0, sizePull = 0;
  logic [16:0] memAddr = 0, bootMemAddrBusOut_r, bootMemAddrBusOe_r;
  logic [7:0] memWrData = 0, memRdData_r, bootMemDataBusIn, bootMemDataBusOut_r;
  logic memReady, memDone_r, eepromSerialIn_r, auxPowerPresent, largeEepromSelect, strapDone;
  logic auxPowerDetectAddrPinIn, eepromSizeSelectAddrPinIn, lowAddrSerialSharedIn;
  logic eepromSelect_r, bootMemDataBusOe_r, bootMemSelectN_r;
  logic bootMemReadEnableN_r, flashWriteStrobeN_r;
  logic expSer;
  int fail_count = 0, checked = 0;
  logic [7:0] expMem [int];
  always #25 clk = ~clk;
  bmp_port bmp_port_inst (.clk, .sys_rst, .memReq, .memWrite, .memAddr, .memWrData,
    .memReady, .memRdData_r, .memDone_r, .eepromMode, .eepromSerialClockReq,
    .eepromSerialOutReq, .eepromSelectReq, .eepromSerialIn_r, .auxPowerPresent,
    .largeEepromSelect, .strapDone, .bootMemAddrBusOut_r, .bootMemAddrBusOe_r,
    .auxPowerDetectAddrPinIn, .eepromSizeSelectAddrPinIn, .lowAddrSerialSharedIn,
    .eepromSelect_r, .bootMemDataBusIn, .bootMemDataBusOut_r, .bootMemDataBusOe_r,
    .bootMemSelectN_r, .bootMemReadEnableN_r, .flashWriteStrobeN_r);
  bmp_mem_model bmp_mem_model_inst (.clk, .selN(bootMemSelectN_r),
    .oeN(bootMemReadEnableN_r), .weN(flashWriteStrobeN_r), .addr(bootMemAddrBusOut_r),
    .addrOe(bootMemAddrBusOe_r), .wrData(bootMemDataBusOut_r), .eeSel(eepromSelect_r),
    .auxPull, .sizePull, .rdData(bootMemDataBusIn), .auxPin(auxPowerDetectAddrPinIn),
    .sizePin(eepromSizeSelectAddrPinIn), .serialIn(lowAddrSerialSharedIn));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic acc(input logic w, input logic [16:0] a, input logic [7:0] d);
    int n = 0;
    while (memReady !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    memReq = 1; memWrite = w; memAddr = a; memWrData = d;
    tick(1);
    memReq = 0;
    n = 0;
    while (memDone_r !== 1'b1 && n < 50)
    begin
      tick(1);
      n++;
    end
    chk(memDone_r, 1);
    if (w) expMem[a] = d;
    else chk(memRdData_r, expMem.exists(a) ? expMem[a] : a[7:0] ^ a[15:8]);
  endtask
  task print_verdict;
    $display("fail_count=%0d checked=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fail_count++;
    print_verdict;
  end
  initial
  begin
    void'($urandom(65599));
    for (int i = 0; i < 4; i++)
    begin
      {auxPull, sizePull} = i[1:0];
      sys_rst = 1;
      tick(2);
      sys_rst = 0;
      tick(12);
      chk(auxPowerPresent, auxPull);
      chk(largeEepromSelect, sizePull);
    end
    acc(1, 17'h1ffff, 8'ha5);
    acc(0, 17'h1ffff, 8'h00);
    repeat (24) acc(1'($urandom), 17'($urandom) & 17'h10003, 8'($urandom));
    eepromMode = 1;
    repeat (8)
    begin
      {eepromSerialClockReq, eepromSerialOutReq, eepromSelectReq} = 3'($urandom);
      expSer = lowAddrSerialSharedIn;
      tick(1);
      chk(eepromSerialIn_r, expSer);
      chk({bootMemAddrBusOut_r[2:1], eepromSelect_r, bootMemAddrBusOe_r[0]},
        {eepromSerialClockReq, eepromSerialOutReq, eepromSelectReq, 1'b0});
      chk(memReady, 0);
    end
    eepromMode = 0;
    acc(0, 17'h10003, 8'h00);
    chk(bootMemAddrBusOe_r, 17'h1ffff);
    print_verdict;
  end
endmodule

// file: bmp_strap_latch.v
// Power-up strap capture for aux power detect and EEPROM size select
`include "bmp_consts.vh"

module bmp_strap_latch #(
  parameter CNT_W = 4
) (
  input wire clk,
  input wire sys_rst,
  input wire auxPinIn,
  input wire sizePinIn,
  output reg strapDone_r,
  output reg auxPowerPresent_r,
  output reg largeEepromSelect_r
);
  localparam integer STRAP_I = `BMP_CYC_MIN(`BMP_STRAP_NS);
  localparam [CNT_W-1:0] STRAP_CYC = STRAP_I[CNT_W-1:0];

  reg [CNT_W-1:0] cnt_r;

  // Pins stay undriven while the count runs, then are sampled once
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      cnt_r <= {CNT_W{1'b0}};
      strapDone_r <= 1'b0;
      auxPowerPresent_r <= 1'b0;
      largeEepromSelect_r <= 1'b0;
    end
    else if (!strapDone_r)
    begin
      if (cnt_r == STRAP_CYC - 1'b1)
      begin
        strapDone_r <= 1'b1;
        auxPowerPresent_r <= auxPinIn;
        largeEepromSelect_r <= sizePinIn;
      end
      else
      begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
